// *** core/cms_core_state.sv ***
// programmer-visible core state: dedicated registers, status word,
// address-map decoding, bank addressing and interrupt level masking
// assumes an AXI4-Lite master on aclk; one write and one read at a time
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module cms_core_state (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////
    logic awready_reg, arready_reg, bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic rd_hit;
    logic wr_fire, ar_fire;
    logic [15:0] pc_reg, acc_reg, temp_reg, index_reg, sp_reg;
    logic [15:0] extra_pointer_reg;
    cms_pkg::cms_psw_t psw_reg;
    cms_pkg::cms_cfg_t cfg_reg;
    logic [15:0] dec_addr_reg;
    logic [2:0] gpr_sel_reg;
    logic [1:0] irq_req_reg;
    logic irq_accept_reg;
    logic op_go;
    cms_pkg::cms_op_t op_code;
    cms_pkg::cms_alu_res_t alu_res;
    cms_pkg::cms_region_t region;
    logic [15:0] ram_top, rom_base, gpr_addr;
    logic [1:0] req_level, cur_level;
    logic [4:0] add_nib;
    logic [8:0] add_wide;

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = awready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    assign wr_fire = awready_reg && s_axi_awvalid && s_axi_wvalid;
    assign ar_fire = arready_reg && s_axi_arvalid;

    ////////////////////////////////////////////////////////////////////
    // bus handshakes; address and data are taken in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= cms_pkg::RESP_OKAY;
        end else begin
            awready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg
                && !bvalid_reg;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known(s_axi_awaddr) ? cms_pkg::RESP_OKAY
                    : cms_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= cms_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
            if (ar_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rdata_next;
                rresp_reg <= rd_hit ? cms_pkg::RESP_OKAY
                    : cms_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    function automatic logic wr_known(input logic [7:0] addr);
        wr_known = (addr <= cms_pkg::OFF_CFG) && (addr[1:0] == 2'h0);
    endfunction

    // byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        merge = old;
        if (strb[0]) merge[7:0] = data[7:0];
        if (strb[1]) merge[15:8] = data[15:8];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // dedicated registers
    assign op_go = wr_fire && (s_axi_awaddr == cms_pkg::OFF_OP)
        && s_axi_wstrb[0];
    assign op_code = cms_pkg::cms_op_t'(s_axi_wdata[2:0]);

    cms_alu u_alu (
        .op (op_code),
        .a (acc_reg[7:0]),
        .b (temp_reg[7:0]),
        .psw (psw_reg),
        .res (alu_res)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_reg <= cms_pkg::WORD_RESET;
        end else if (wr_fire && s_axi_awaddr == cms_pkg::OFF_PC) begin
            pc_reg <= merge(pc_reg, s_axi_wdata, s_axi_wstrb);
        end else if (op_go && op_code == cms_pkg::OP_STEP) begin
            pc_reg <= pc_reg + 16'h0001;
        end
    end

    // only the low byte moves on byte operations; the high byte is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= cms_pkg::WORD_RESET;
        end else if (wr_fire && s_axi_awaddr == cms_pkg::OFF_ACC) begin
            acc_reg <= merge(acc_reg, s_axi_wdata, s_axi_wstrb);
        end else if (op_go && op_code inside {cms_pkg::OP_ADD,
            cms_pkg::OP_SUB, cms_pkg::OP_SHL, cms_pkg::OP_SHR}) begin
            acc_reg[7:0] <= alu_res.value;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp_reg <= cms_pkg::WORD_RESET;
            index_reg <= cms_pkg::WORD_RESET;
            extra_pointer_reg <= cms_pkg::WORD_RESET;
            sp_reg <= cms_pkg::WORD_RESET;
        end else if (wr_fire) begin
            if (s_axi_awaddr == cms_pkg::OFF_TEMP)
                temp_reg <= merge(temp_reg, s_axi_wdata, s_axi_wstrb);
            if (s_axi_awaddr == cms_pkg::OFF_INDEX)
                index_reg <= merge(index_reg, s_axi_wdata, s_axi_wstrb);
            if (s_axi_awaddr == cms_pkg::OFF_EXTRA_POINTER)
                extra_pointer_reg <= merge(extra_pointer_reg, s_axi_wdata,
                    s_axi_wstrb);
            if (s_axi_awaddr == cms_pkg::OFF_SP)
                sp_reg <= merge(sp_reg, s_axi_wdata, s_axi_wstrb);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status word; with small RAM only sixteen banks exist, so the top
    // bank bit is held at zero rather than aliasing into the next bank
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psw_reg <= cms_pkg::PSW_RESET;
        end else if (wr_fire && s_axi_awaddr == cms_pkg::OFF_PSW) begin
            psw_reg <= merge(psw_reg, s_axi_wdata, s_axi_wstrb);
            psw_reg.unused <= 3'h0;
            if (!cfg_reg.large_ram && s_axi_wstrb[1])
                psw_reg.bank_pointer[4] <= 1'b0;
        end else if (wr_fire && s_axi_awaddr == cms_pkg::OFF_CFG
            && s_axi_wstrb[0] && !s_axi_wdata[0]) begin
            psw_reg.bank_pointer[4] <= 1'b0;
        end else if (op_go && op_code inside {cms_pkg::OP_ADD,
            cms_pkg::OP_SUB, cms_pkg::OP_SHL, cms_pkg::OP_SHR}) begin
            psw_reg.half_carry <= alu_res.half_carry;
            psw_reg.negative <= alu_res.negative;
            psw_reg.zero <= alu_res.zero;
            psw_reg.overflow <= alu_res.overflow;
            psw_reg.carry <= alu_res.carry;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= cms_pkg::CFG_RESET;
            dec_addr_reg <= cms_pkg::WORD_RESET;
            gpr_sel_reg <= 3'h0;
            irq_req_reg <= 2'h0;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == cms_pkg::OFF_CFG)
                cfg_reg <= s_axi_wdata[1:0];
            if (s_axi_awaddr == cms_pkg::OFF_DECODE)
                dec_addr_reg <= merge(dec_addr_reg, s_axi_wdata,
                    s_axi_wstrb);
            if (s_axi_awaddr == cms_pkg::OFF_GPR)
                gpr_sel_reg <= s_axi_wdata[2:0];
            if (s_axi_awaddr == cms_pkg::OFF_IRQ)
                irq_req_reg <= s_axi_wdata[2:1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address map; vectors win over ROM at the very top
    assign ram_top = cfg_reg.large_ram ? cms_pkg::RAM_TOP_LARGE
        : cms_pkg::RAM_TOP_SMALL;
    assign rom_base = cfg_reg.piggyback ? cms_pkg::ROM_BASE_PIGGY
        : cms_pkg::ROM_BASE_MASK;

    always_comb begin
        if (dec_addr_reg <= cms_pkg::PERIPH_TOP)
            region = cms_pkg::REGION_PERIPH;
        else if (dec_addr_reg <= ram_top)
            region = cms_pkg::REGION_RAM;
        else if (dec_addr_reg >= cms_pkg::VECTOR_BASE)
            region = cms_pkg::REGION_VECTOR;
        else if (dec_addr_reg >= rom_base)
            region = cms_pkg::REGION_ROM;
        else
            region = cms_pkg::REGION_NONE;
    end

    assign gpr_addr = {cms_pkg::GPR_PREFIX, psw_reg.bank_pointer,
        gpr_sel_reg};

    // levels 00 and 01 are one level; a smaller number outranks
    function automatic logic [1:0] level_of(input logic [1:0] code);
        level_of = (code == 2'h0) ? 2'h1 : code;
    endfunction

    assign req_level = level_of(irq_req_reg);
    assign cur_level = level_of({psw_reg.irq_level_hi,
        psw_reg.irq_level_lo});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_accept_reg <= 1'b0;
        end else begin
            irq_accept_reg <= psw_reg.irq_enable
                && (req_level < cur_level);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            cms_pkg::OFF_PC: rdata_next[15:0] = pc_reg;
            cms_pkg::OFF_ACC: rdata_next[15:0] = acc_reg;
            cms_pkg::OFF_TEMP: rdata_next[15:0] = temp_reg;
            cms_pkg::OFF_INDEX: rdata_next[15:0] = index_reg;
            cms_pkg::OFF_EXTRA_POINTER: rdata_next[15:0] = extra_pointer_reg;
            cms_pkg::OFF_SP: rdata_next[15:0] = sp_reg;
            cms_pkg::OFF_PSW: rdata_next[15:0] = psw_reg;
            cms_pkg::OFF_OP: rdata_next = 32'h0000_0000;
            cms_pkg::OFF_DECODE: rdata_next[18:0] = {region, dec_addr_reg};
            cms_pkg::OFF_GPR: rdata_next[15:0] = gpr_addr;
            cms_pkg::OFF_IRQ: rdata_next[2:0] = {irq_req_reg, irq_accept_reg};
            cms_pkg::OFF_CFG: rdata_next[1:0] = cfg_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    assign add_wide = {1'b0, acc_reg[7:0]} + {1'b0, temp_reg[7:0]};
    assign add_nib = {1'b0, acc_reg[3:0]} + {1'b0, temp_reg[3:0]};

    sequence s_add_issued;
        op_go && op_code == cms_pkg::OP_ADD;
    endsequence

    sequence s_arith_issued;
        op_go && op_code inside {cms_pkg::OP_ADD, cms_pkg::OP_SUB,
            cms_pkg::OP_SHL, cms_pkg::OP_SHR};
    endsequence

    a_irq_reset_clear: assert property (@(posedge aclk)
        $rose(aresetn) |-> !psw_reg.irq_enable)
        else $error("irq enable not cleared by reset");

    a_acc_high_kept: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_arith_issued |=> acc_reg[15:8] == $past(acc_reg[15:8]))
        else $error("byte operation changed accumulator high byte");

    a_add_carry_out: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_add_issued |=> psw_reg.carry == $past(add_wide[8])
            && acc_reg[7:0] == $past(add_wide[7:0]))
        else $error("add carry or sum wrong");

    a_add_half_carry: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_add_issued |=> psw_reg.half_carry == $past(add_nib[4]))
        else $error("half carry wrong after add");

    a_zero_neg_flags: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_arith_issued |=> psw_reg.zero == (acc_reg[7:0] == 8'h00)
            && psw_reg.negative == acc_reg[7])
        else $error("zero or negative flag disagrees with result");

    a_sub_overflow: assert property (@(posedge aclk)
        disable iff (!aresetn)
        op_go && op_code == cms_pkg::OP_SUB |=> psw_reg.overflow ==
            ($past(acc_reg[7]) != $past(temp_reg[7])
            && acc_reg[7] != $past(acc_reg[7])))
        else $error("overflow wrong after subtract");

    a_gpr_address: assert property (@(posedge aclk)
        disable iff (!aresetn)
        gpr_addr[15:8] == 8'h01 && gpr_addr[7:3] == psw_reg[15:11])
        else $error("register bank address malformed");

    a_bank_limit: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !cfg_reg.large_ram |-> !psw_reg.bank_pointer[4])
        else $error("bank beyond sixteen with small RAM");

    a_irq_masking: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ##1 irq_accept_reg == ($past(psw_reg.irq_enable)
            && $past(req_level) < $past(cur_level)))
        else $error("interrupt acceptance wrong");

    a_periph_region: assert property (@(posedge aclk)
        disable iff (!aresetn)
        dec_addr_reg < 16'h0080 |-> region == cms_pkg::REGION_PERIPH)
        else $error("low address not peripheral");

    a_write_answer: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid ##0 (!s_axi_awready)[*1])
        else $error("write not answered next cycle");
endmodule

// *** pkg/cms_pkg.sv ***
// constants, types and register map of the core state block
// assumes a 32-bit AXI4-Lite master on the same clock as the core
package cms_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_PC = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_TEMP = 8'h08;
    localparam logic [7:0] OFF_INDEX = 8'h0C;
    localparam logic [7:0] OFF_EXTRA_POINTER = 8'h10;
    localparam logic [7:0] OFF_SP = 8'h14;
    localparam logic [7:0] OFF_PSW = 8'h18;
    localparam logic [7:0] OFF_OP = 8'h1C;
    localparam logic [7:0] OFF_DECODE = 8'h20;
    localparam logic [7:0] OFF_GPR = 8'h24;
    localparam logic [7:0] OFF_IRQ = 8'h28;
    localparam logic [7:0] OFF_CFG = 8'h2C;

    // address map of the 64 Kbyte space
    localparam logic [15:0] PERIPH_TOP = 16'h007F;
    localparam logic [15:0] RAM_BASE = 16'h0080;
    localparam logic [15:0] RAM_TOP_SMALL = 16'h027F;
    localparam logic [15:0] RAM_TOP_LARGE = 16'h047F;
    localparam logic [15:0] ROM_BASE_MASK = 16'hE000;
    localparam logic [15:0] ROM_BASE_PIGGY = 16'h8000;
    localparam logic [15:0] VECTOR_BASE = 16'hFFC0;

    // general-purpose register address prefix: seven zeros then a one
    localparam logic [7:0] GPR_PREFIX = 8'h01;

    // reset values
    localparam logic [15:0] PSW_RESET = 16'h0030;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] CFG_RESET = 2'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REGION_PERIPH,
        REGION_RAM,
        REGION_ROM,
        REGION_VECTOR,
        REGION_NONE
    } cms_region_t;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_ADD,
        OP_SUB,
        OP_SHL,
        OP_SHR,
        OP_STEP
    } cms_op_t;

    typedef struct packed {
        logic [4:0] bank_pointer;
        logic [2:0] unused;
        logic half_carry;
        logic irq_enable;
        logic irq_level_hi;
        logic irq_level_lo;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } cms_psw_t;

    typedef struct packed {
        logic [7:0] value;
        logic half_carry;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } cms_alu_res_t;

    typedef struct packed {
        logic piggyback;
        logic large_ram;
    } cms_cfg_t;

endpackage

// *** core/cms_alu.sv ***
// byte arithmetic and shifts with condition-code generation
// assumes operands come straight from the accumulator and temp registers
`timescale 1ns/100ps
module cms_alu (
    // operation
    input wire cms_pkg::cms_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire cms_pkg::cms_psw_t psw,
    // result
    output cms_pkg::cms_alu_res_t res
);
    logic [8:0] wide;
    logic [4:0] nib;

    always_comb begin
        wide = {1'b0, a};
        nib = 5'h00;
        res.half_carry = psw.half_carry;
        res.overflow = psw.overflow;
        unique case (op)
            cms_pkg::OP_ADD: begin
                wide = {1'b0, a} + {1'b0, b};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                res.half_carry = nib[4];
                res.overflow = (a[7] == b[7]) && (wide[7] != a[7]);
            end
            cms_pkg::OP_SUB: begin
                wide = {1'b0, a} - {1'b0, b};
                nib = {1'b0, a[3:0]} - {1'b0, b[3:0]};
                res.half_carry = nib[4];
                res.overflow = (a[7] != b[7]) && (wide[7] != a[7]);
            end
            // shifts park the bit pushed out where the carry goes
            cms_pkg::OP_SHL: wide = {a[7], a[6:0], 1'b0};
            cms_pkg::OP_SHR: wide = {a[0], 1'b0, a[7:1]};
            default: wide = {psw.carry, a};
        endcase
        res.value = wide[7:0];
        res.carry = wide[8];
        res.negative = wide[7];
        res.zero = (wide[7:0] == 8'h00);
    end
endmodule

// *** bench/cpu_core_state_and_memory_map_test.sv ***
// self-checking bench for the core state block over its AXI4-Lite port
// assumes cms_core_state on one 100 MHz clock, synchronous active-low reset
`timescale 1ns/100ps
module cpu_core_state_and_memory_map_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, q;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int n_fail, checks_done;
    // one access per row: optional write, then read back the same offset
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [15:0] d;
        logic [19:0] e;
    } cms_row_t;
    cms_row_t rows [0:58] = '{
        '{1'b1, 8'h00, 16'hABCD, 20'h0ABCD},
        '{1'b1, 8'h04, 16'h1234, 20'h01234},
        '{1'b1, 8'h08, 16'h5678, 20'h05678},
        '{1'b1, 8'h0C, 16'hBEEF, 20'h0BEEF},
        '{1'b1, 8'h10, 16'h2468, 20'h02468},
        '{1'b1, 8'h14, 16'h1357, 20'h01357},
        '{1'b1, 8'h2C, 16'h0003, 20'h00003},
        '{1'b1, 8'h18, 16'hFFFF, 20'h0F8FF},
        '{1'b1, 8'h24, 16'h0005, 20'h001FD},
        '{1'b1, 8'h20, 16'h007F, 20'h0007F},
        '{1'b1, 8'h20, 16'h0080, 20'h10080},
        '{1'b1, 8'h20, 16'h047F, 20'h1047F},
        '{1'b1, 8'h20, 16'h8000, 20'h28000},
        '{1'b1, 8'h20, 16'hFFC0, 20'h3FFC0},
        '{1'b1, 8'h20, 16'h0480, 20'h40480},
        '{1'b1, 8'h2C, 16'h0000, 20'h00000},
        '{1'b0, 8'h18, 16'h0000, 20'h078FF},
        '{1'b0, 8'h24, 16'h0000, 20'h0017D},
        '{1'b1, 8'h20, 16'h047F, 20'h4047F},
        '{1'b1, 8'h20, 16'h027F, 20'h1027F},
        '{1'b1, 8'h20, 16'hE000, 20'h2E000},
        '{1'b1, 8'h20, 16'h8000, 20'h48000},
        '{1'b1, 8'h18, 16'h0000, 20'h00000},
        '{1'b1, 8'h04, 16'h1278, 20'h01278},
        '{1'b1, 8'h08, 16'h0008, 20'h00008},
        '{1'b1, 8'h1C, 16'h0001, 20'h00000},
        '{1'b0, 8'h04, 16'h0000, 20'h01280},
        '{1'b0, 8'h18, 16'h0000, 20'h0008A},
        '{1'b1, 8'h08, 16'h0081, 20'h00081},
        '{1'b1, 8'h1C, 16'h0002, 20'h00000},
        '{1'b0, 8'h04, 16'h0000, 20'h012FF},
        '{1'b0, 8'h18, 16'h0000, 20'h00089},
        '{1'b1, 8'h08, 16'h00FF, 20'h000FF},
        '{1'b1, 8'h1C, 16'h0002, 20'h00000},
        '{1'b0, 8'h04, 16'h0000, 20'h01200},
        '{1'b0, 8'h18, 16'h0000, 20'h00004},
        '{1'b1, 8'h04, 16'h00C1, 20'h000C1},
        '{1'b1, 8'h1C, 16'h0003, 20'h00000},
        '{1'b0, 8'h04, 16'h0000, 20'h00082},
        '{1'b0, 8'h18, 16'h0000, 20'h00009},
        '{1'b1, 8'h04, 16'h0041, 20'h00041},
        '{1'b1, 8'h1C, 16'h0004, 20'h00000},
        '{1'b0, 8'h04, 16'h0000, 20'h00020},
        '{1'b0, 8'h18, 16'h0000, 20'h00001},
        '{1'b1, 8'h1C, 16'h0005, 20'h00000},
        '{1'b0, 8'h00, 16'h0000, 20'h0ABCE},
        '{1'b1, 8'h1C, 16'h0000, 20'h00000},
        '{1'b0, 8'h18, 16'h0000, 20'h00001},
        '{1'b1, 8'h18, 16'h0060, 20'h00060},
        '{1'b1, 8'h28, 16'h0000, 20'h00001},
        '{1'b1, 8'h28, 16'h0002, 20'h00003},
        '{1'b1, 8'h28, 16'h0004, 20'h00004},
        '{1'b1, 8'h28, 16'h0006, 20'h00006},
        '{1'b1, 8'h18, 16'h0070, 20'h00070},
        '{1'b1, 8'h28, 16'h0004, 20'h00005},
        '{1'b1, 8'h18, 16'h0050, 20'h00050},
        '{1'b1, 8'h28, 16'h0000, 20'h00000},
        '{1'b1, 8'h18, 16'h0020, 20'h00020},
        '{1'b1, 8'h28, 16'h0000, 20'h00000}
    };

    cms_core_state dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] got,
            input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // valids stay up until their ready edge; bready held until bvalid
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        check("wready", {31'h0, wready}, 32'h0000_0001);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // generous: the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        $display("BAD watchdog expected finish seen hang");
        results();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        n_fail = 0;
        checks_done = 0;
        do_reset();
        axi_rd(8'h18, q, r);
        check("psw after reset", q, 32'h0000_0030);
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].w) begin
                axi_wr(rows[i].a, {16'h0000, rows[i].d}, r);
                check("bresp", {30'h0, r}, 32'h0000_0000);
            end
            axi_rd(rows[i].a, q, r);
            check("rdata", q, {12'h000, rows[i].e});
            check("rresp", {30'h0, r}, 32'h0000_0000);
        end
        $display("test table done");
        // unmapped and unaligned offsets are refused
        axi_wr(8'h30, 32'h0000_FFFF, r);
        check("bresp unmapped", {30'h0, r}, 32'h0000_0002);
        axi_wr(8'h06, 32'h0000_FFFF, r);
        check("bresp unaligned", {30'h0, r}, 32'h0000_0002);
        axi_rd(8'h04, q, r);
        check("acc untouched", q, 32'h0000_0020);
        axi_rd(8'h30, q, r);
        check("rresp unmapped", {30'h0, r}, 32'h0000_0002);
        check("rdata unmapped", q, 32'h0000_0000);
        $display("test refusal done");
        // second reset in mid-run brings the status word and accumulator back to their reset values
        do_reset();
        axi_rd(8'h18, q, r);
        check("psw after rerun", q, 32'h0000_0030);
        axi_rd(8'h04, q, r);
        check("acc after rerun", q, 32'h0000_0000);
        $display("test second reset done");
        results();
    end
endmodule
